// *** tom_io_map.v ***
// Process data mapping and output control for transparent and overload-relay modes.
// Assumes command image bytes arrive synchronous to mclk; local inputs are asynchronous pins.
`timescale 1ns/1ps
`include "tom_defines.vh"

module tom_io_map #(
  parameter integer BLINK_CYCLES = `TOM_BLINK_CYCLES
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        mode_overload,
  input  wire        relay_c_is_fault_out,
  input  wire        aux_is_fault_out,
  input  wire        emergency_enable,
  input  wire [7:0]  cmd_byte0,
  input  wire [7:0]  cmd_byte1,
  input  wire [7:0]  cmd_byte2,
  input  wire        relay_d_cmd,
  input  wire        overload_trip,
  input  wire        overload_warning,
  input  wire        input_fault,
  input  wire        other_warning,
  input  wire [15:0] motor_current,
  input  wire [15:0] thermal_load,
  input  wire [15:0] time_to_trip,
  input  wire [15:0] time_to_restart,
  input  wire [15:0] spare_word,
  input  wire [7:0]  expansion_inputs,
  input  wire        local_input_a,
  input  wire        local_input_b,
  input  wire        local_input_c,
  input  wire        local_input_d,
  input  wire        local_input_e,
  input  wire        local_input_f,
  output reg         relay_output_a,
  output reg         relay_output_b,
  output reg         relay_output_c,
  output reg         relay_output_d,
  output reg         aux_supply_output,
  output reg  [3:0]  expansion_outputs,
  output reg  [127:0] mon_image,
  output reg         red_lamp,
  output reg         panel_fault_lamp,
  output reg         thermal_clear,
  output reg         input_fault_mask
);

  // Fault supervision states, one-hot.
  localparam [1:0] FLT_CLEAR   = 2'b01;
  localparam [1:0] FLT_TRIPPED = 2'b10;

  // Local input pins in ascending order, input a in bit 0.
  wire [5:0]   pins;
  reg  [5:0]   sync1;
  reg  [5:0]   sync2;
  reg  [1:0]   fault_state;
  reg  [1:0]   next_fault_state;
  reg          prev_emerg;
  reg  [31:0]  blink_cnt;
  reg  [31:0]  next_blink_cnt;
  reg          blink;
  reg          next_blink;
  reg          next_relay_output_a;
  reg          next_relay_output_b;
  reg          next_relay_output_c;
  reg          next_relay_output_d;
  reg          next_aux_supply_output;
  reg  [3:0]   next_expansion_outputs;
  reg          next_red_lamp;
  reg          next_panel_fault_lamp;
  reg          next_thermal_clear;
  reg          next_input_fault_mask;
  reg  [7:0]   next_mon_byte0;
  reg  [7:0]   next_mon_byte1;
  wire [15:0]  mon_word1;
  wire [15:0]  mon_word2;
  wire [15:0]  mon_word3;
  wire [15:0]  mon_word4;
  wire [15:0]  mon_word5;
  wire [7:0]   mon_byte12;
  wire [23:0]  mon_tail;
  wire [127:0] next_mon_image;

  assign pins[0] = local_input_a;
  assign pins[1] = local_input_b;
  assign pins[2] = local_input_c;
  assign pins[3] = local_input_d;
  assign pins[4] = local_input_e;
  assign pins[5] = local_input_f;

  wire emerg_bit  = cmd_byte0[`TOM_CMD0_PREP_EMERG];
  wire reset_bit  = cmd_byte0[`TOM_CMD0_FAULT_RESET];
  wire emerg_hold = emergency_enable & emerg_bit;
  wire emerg_rise = emerg_hold & ~prev_emerg;
  // Input faults are ignored while emergency start is held, if enabled.
  wire eff_in_flt = input_fault & ~emerg_hold;
  // A summary fault is a latched fault, a live overload trip or an unmasked input fault.
  wire raw_fault  = overload_trip | eff_in_flt;
  wire latched    = (fault_state == FLT_TRIPPED);
  wire fault_now  = latched | raw_fault;
  wire warn_now   = overload_warning | other_warning;
  wire is_ovl     = (mode_overload == `TOM_MODE_OVERLOAD);
  wire blink_wrap = (blink_cnt >= BLINK_CYCLES - 1);

  // Each local input pin passes two flip-flops before any logic reads it.
  // Only the second stage feeds the monitoring image.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge mclk) begin
        if (rst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // A new fault wins over a reset command in the same cycle.
  // The trip state holds until the master sends fault reset.
  always @* begin
    next_fault_state = fault_state;
    case (fault_state)
      FLT_CLEAR: begin
        if (raw_fault) begin
          next_fault_state = FLT_TRIPPED;
        end
      end
      FLT_TRIPPED: begin
        if (!raw_fault && reset_bit) begin
          next_fault_state = FLT_CLEAR;
        end
      end
      default: begin
        next_fault_state = FLT_CLEAR;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      fault_state <= FLT_CLEAR;
    end else begin
      fault_state <= next_fault_state;
    end
  end

  // The emergency edge clears the thermal memory with a one-cycle pulse.
  // The previous value follows the raw bit, so a held bit never retriggers.
  always @* begin
    next_thermal_clear    = emerg_rise;
    next_input_fault_mask = emerg_hold;
  end

  always @(posedge mclk) begin
    if (rst) begin
      prev_emerg       <= 1'b0;
      thermal_clear    <= 1'b0;
      input_fault_mask <= 1'b0;
    end else begin
      prev_emerg       <= emerg_bit;
      thermal_clear    <= next_thermal_clear;
      input_fault_mask <= next_input_fault_mask;
    end
  end

  // Flash timer for the panel fault indication.
  // The lamp starts in whatever phase the timer has when a fault arrives.
  always @* begin
    if (blink_wrap) begin
      next_blink_cnt = 32'h00000000;
      next_blink     = ~blink;
    end else begin
      next_blink_cnt = blink_cnt + 32'h00000001;
      next_blink     = blink;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      blink_cnt <= 32'h00000000;
      blink     <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
    end
  end

  // No start/stop sequencing, checkback, simulation, bus-fault or dip logic exists here.
  // A fault output on relay c or the aux supply overrides its bus bit.
  always @* begin
    next_expansion_outputs = cmd_byte2[3:0];
    next_relay_output_d    = relay_d_cmd;
    if (relay_c_is_fault_out) begin
      next_relay_output_c = fault_now;
    end else begin
      next_relay_output_c = cmd_byte1[`TOM_CMD1_RELAY_C];
    end
    if (aux_is_fault_out) begin
      next_aux_supply_output = fault_now;
    end else begin
      next_aux_supply_output = cmd_byte1[`TOM_CMD1_AUX_SUPPLY];
    end
    next_red_lamp = fault_now;
    if (is_ovl) begin
      next_relay_output_a   = ~fault_now;
      next_relay_output_b   = fault_now;
      next_panel_fault_lamp = fault_now & blink;
    end else begin
      next_relay_output_a   = cmd_byte1[`TOM_CMD1_RELAY_A];
      next_relay_output_b   = cmd_byte1[`TOM_CMD1_RELAY_B];
      next_panel_fault_lamp = fault_now;
    end
  end

  // Outputs are registered; reset leaves every relay open.
  always @(posedge mclk) begin
    if (rst) begin
      relay_output_a    <= 1'b0;
      relay_output_b    <= 1'b0;
      relay_output_c    <= 1'b0;
      relay_output_d    <= 1'b0;
      aux_supply_output <= 1'b0;
      expansion_outputs <= 4'h0;
      red_lamp          <= 1'b0;
      panel_fault_lamp  <= 1'b0;
    end else begin
      relay_output_a    <= next_relay_output_a;
      relay_output_b    <= next_relay_output_b;
      relay_output_c    <= next_relay_output_c;
      relay_output_d    <= next_relay_output_d;
      aux_supply_output <= next_aux_supply_output;
      expansion_outputs <= next_expansion_outputs;
      red_lamp          <= next_red_lamp;
      panel_fault_lamp  <= next_panel_fault_lamp;
    end
  end

  // Monitoring bytes 0 and 1; the unused bits stay zero.
  always @* begin
    next_mon_byte0                           = 8'h00;
    next_mon_byte0[`TOM_MON0_SUM_WARN]       = warn_now;
    next_mon_byte0[`TOM_MON0_SUM_FAULT]      = fault_now;
    next_mon_byte0[`TOM_MON0_OVL_WARN]       = overload_warning;
    next_mon_byte1                           = 8'h00;
    next_mon_byte1[`TOM_MON1_INPUT_LSB +: 6] = sync2;
  end

  // Words are little-endian byte pairs; bytes 13 to 15 are unused.
  assign mon_word1  = motor_current;
  assign mon_word2  = thermal_load;
  assign mon_word3  = time_to_trip;
  assign mon_word4  = time_to_restart;
  assign mon_word5  = spare_word;
  assign mon_byte12 = expansion_inputs;
  assign mon_tail   = 24'h000000;

  assign next_mon_image = {mon_tail,
                           mon_byte12,
                           mon_word5,
                           mon_word4,
                           mon_word3,
                           mon_word2,
                           mon_word1,
                           next_mon_byte1,
                           next_mon_byte0};

  // The whole image updates in one cycle, so a master never sees a torn word.
  always @(posedge mclk) begin
    if (rst) begin
      mon_image <= 128'h0;
    end else begin
      mon_image <= next_mon_image;
    end
  end

endmodule

// *** tom_defines.vh ***
// Bit positions and constants for the transparent / overload-relay process image block.
// Included by tom_io_map.v; definitions only.
`ifndef TOM_DEFINES_VH
`define TOM_DEFINES_VH
`define TOM_MODE_TRANSPARENT  1'b0
`define TOM_MODE_OVERLOAD     1'b1
`define TOM_MON0_SUM_WARN     7
`define TOM_MON0_SUM_FAULT    6
`define TOM_MON0_OVL_WARN     3
`define TOM_MON1_INPUT_LSB    2
`define TOM_CMD0_FAULT_RESET  6
`define TOM_CMD0_PREP_EMERG   4
`define TOM_CMD1_RELAY_C      7
`define TOM_CMD1_RELAY_B      6
`define TOM_CMD1_RELAY_A      5
`define TOM_CMD1_AUX_SUPPLY   4
`define TOM_MON_BYTES         16
`define TOM_CMD_BYTES         8
`define TOM_BLINK_MS          500
`define TOM_BLINK_CYCLES      ((`TOM_BLINK_MS * 40000) / 2)
`endif

// *** tom_io_map_checker.sv ***
// Port checker for tom_io_map.
// Assumes one mclk domain with synchronous rst.
`timescale 1ns/1ps
module tom_io_map_checker (
  input wire         mclk, rst, mode_overload, relay_c_is_fault_out, emergency_enable,
  input wire         overload_trip, overload_warning, thermal_clear,
  input wire         relay_output_a, relay_output_b, relay_output_c, red_lamp,
  input wire [7:0]   cmd_byte0, cmd_byte1, cmd_byte2,
  input wire [3:0]   expansion_outputs,
  input wire [127:0] mon_image
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_trip; mode_overload && overload_trip; endsequence
  sequence s_hold; mode_overload && !overload_trip && !cmd_byte0[6]; endsequence
  property p_trip; s_trip |=> !relay_output_a && relay_output_b && red_lamp && mon_image[6]; endproperty
  a_trip: assert property (p_trip) else $error("trip");
  property p_hold; s_trip ##1 s_hold |=> relay_output_b && mon_image[6]; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_fout; relay_c_is_fault_out && mode_overload && overload_trip |=> relay_output_c; endproperty
  a_fout: assert property (p_fout) else $error("fout");
  property p_relc; !relay_c_is_fault_out |=> relay_output_c == $past(cmd_byte1[7]); endproperty
  a_relc: assert property (p_relc) else $error("relc");
  property p_tra; !mode_overload |=> relay_output_a == $past(cmd_byte1[5])
    && relay_output_b == $past(cmd_byte1[6]); endproperty
  a_tra: assert property (p_tra) else $error("tra");
  property p_exp; 1 |=> expansion_outputs == $past(cmd_byte2[3:0]); endproperty
  a_exp: assert property (p_exp) else $error("exp");
  property p_mon0; 1 |=> mon_image[3] == $past(overload_warning) && mon_image[5:4] == 2'h0; endproperty
  a_mon0: assert property (p_mon0) else $error("mon0");
  property p_emg; emergency_enable && $rose(cmd_byte0[4]) |=> thermal_clear; endproperty
  a_emg: assert property (p_emg) else $error("emg");
endmodule
bind tom_io_map tom_io_map_checker chk_u (
  .mclk(mclk), .rst(rst), .mode_overload(mode_overload), .relay_c_is_fault_out(relay_c_is_fault_out),
  .emergency_enable(emergency_enable), .overload_trip(overload_trip), .overload_warning(overload_warning),
  .thermal_clear(thermal_clear), .relay_output_a(relay_output_a), .relay_output_b(relay_output_b),
  .relay_output_c(relay_output_c), .red_lamp(red_lamp), .cmd_byte0(cmd_byte0), .cmd_byte1(cmd_byte1),
  .cmd_byte2(cmd_byte2), .expansion_outputs(expansion_outputs), .mon_image(mon_image));

// *** tom_plc.sv ***
// Bus master model packing commands into the image.
// Assumes inputs change just after mclk edges.
`timescale 1ns/1ps
module tom_plc (
  input  wire       frst,
  input  wire       emg,
  input  wire [3:0] rel,
  input  wire [3:0] exo,
  output wire [7:0] cmd_byte0,
  output wire [7:0] cmd_byte1,
  output wire [7:0] cmd_byte2
);
  assign cmd_byte0 = {1'b0, frst, 1'b0, emg, 4'h0};
  assign cmd_byte1 = {rel, 4'h0};
  assign cmd_byte2 = {4'h0, exo};
endmodule

// *** tom_io_map_tb.sv ***
// Self-checking bench for tom_io_map.
// Assumes tom_plc and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, e); end end
module tom_io_map_tb;
  reg mclk = 0, rst = 1, mode_overload = 0, relay_c_is_fault_out = 0, aux_is_fault_out = 0, emergency_enable = 0;
  reg relay_d_cmd = 0, overload_trip = 0, overload_warning = 0, input_fault = 0, other_warning = 0, frst = 0, emg = 0;
  reg [15:0] motor_current = 0, thermal_load = 0, time_to_trip = 0, time_to_restart = 0, spare_word = 0;
  reg [7:0] expansion_inputs = 0;
  reg [5:0] din = 0;
  reg [3:0] rel = 0, exo = 0;
  wire local_input_a = din[0], local_input_b = din[1], local_input_c = din[2];
  wire local_input_d = din[3], local_input_e = din[4], local_input_f = din[5];
  wire [7:0] cmd_byte0, cmd_byte1, cmd_byte2;
  wire relay_output_a, relay_output_b, relay_output_c, relay_output_d, aux_supply_output;
  wire red_lamp, panel_fault_lamp, thermal_clear, input_fault_mask;
  wire [3:0] expansion_outputs;
  wire [127:0] mon_image;
  integer error_cnt = 0, checks = 0, i, n;
  reg mdl_flt = 0;
  reg [7:0] exp_out;
  reg [119:0] exp_mon;
  tom_plc plc_u (.frst(frst), .emg(emg), .rel(rel), .exo(exo), .cmd_byte0(cmd_byte0), .cmd_byte1(cmd_byte1),
    .cmd_byte2(cmd_byte2));
  tom_io_map #(.BLINK_CYCLES(4)) dut_u (.mclk(mclk), .rst(rst), .mode_overload(mode_overload),
    .relay_c_is_fault_out(relay_c_is_fault_out), .aux_is_fault_out(aux_is_fault_out),
    .emergency_enable(emergency_enable), .cmd_byte0(cmd_byte0), .cmd_byte1(cmd_byte1), .cmd_byte2(cmd_byte2),
    .relay_d_cmd(relay_d_cmd), .overload_trip(overload_trip), .overload_warning(overload_warning),
    .input_fault(input_fault), .other_warning(other_warning), .motor_current(motor_current),
    .thermal_load(thermal_load), .time_to_trip(time_to_trip), .time_to_restart(time_to_restart),
    .spare_word(spare_word), .expansion_inputs(expansion_inputs), .local_input_a(local_input_a),
    .local_input_b(local_input_b), .local_input_c(local_input_c), .local_input_d(local_input_d),
    .local_input_e(local_input_e), .local_input_f(local_input_f), .relay_output_a(relay_output_a),
    .relay_output_b(relay_output_b), .relay_output_c(relay_output_c), .relay_output_d(relay_output_d),
    .aux_supply_output(aux_supply_output), .expansion_outputs(expansion_outputs), .mon_image(mon_image),
    .red_lamp(red_lamp), .panel_fault_lamp(panel_fault_lamp), .thermal_clear(thermal_clear),
    .input_fault_mask(input_fault_mask));
  // Reference fault state from the rules: unmasked faults latch, fault reset clears.
  always @(posedge mclk) begin
    if (rst) begin
      mdl_flt <= 1'b0;
    end else if (overload_trip || (input_fault && !(emergency_enable && emg))) begin
      mdl_flt <= 1'b1;
    end else if (frst) begin
      mdl_flt <= 1'b0;
    end
  end
  initial forever #12.5 mclk = ~mclk;
  task step(input integer k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task test_done;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
  initial begin
    n = $urandom(33);
    step(4);
    rst = 0;
    mode_overload = 1;
    step(2);
    `CHK({relay_output_a, relay_output_b}, 2'b10)
    for (i = 0; i < 12; i++) begin
      mode_overload = i[0];
      {motor_current, thermal_load} = $urandom;
      {time_to_trip, time_to_restart} = $urandom;
      {spare_word, expansion_inputs, rel, exo} = $urandom;
      {din, overload_warning, relay_d_cmd, other_warning} = 9'($urandom);
      step(4);
      exp_out = {rel[3], i[0] ? 2'b01 : rel[2:1], rel[0], exo};
      exp_mon = {24'h0, expansion_inputs, spare_word, time_to_restart, time_to_trip, thermal_load,
                 motor_current, din, 2'b00};
      `CHK({relay_output_c, relay_output_b, relay_output_a, aux_supply_output, expansion_outputs}, exp_out)
      `CHK({relay_output_d, mon_image[3]}, {relay_d_cmd, overload_warning})
      `CHK(mon_image[7:0], {overload_warning | other_warning, 3'b000, overload_warning, 3'b000})
      `CHK(mon_image[127:8], exp_mon)
    end
    relay_c_is_fault_out = 1;
    aux_is_fault_out = 1;
    overload_trip = 1;
    step(1);
    overload_trip = 0;
    step(2);
    `CHK({relay_output_a, relay_output_b, relay_output_c, aux_supply_output, red_lamp, mon_image[6]}, 6'h1f)
    n = 0;
    for (i = 0; i < 20; i++) begin
      step(1);
      n += panel_fault_lamp;
    end
    `CHK(n > 4 && n < 16, 1'b1)
    frst = 1;
    step(1);
    frst = 0;
    step(3);
    `CHK({relay_output_a, relay_output_b, red_lamp}, 3'b100)
    `CHK(relay_output_b, mdl_flt)
    emergency_enable = 1;
    emg = 1;
    step(1);
    `CHK({thermal_clear, input_fault_mask}, 2'b11)
    input_fault = 1;
    step(1);
    `CHK({thermal_clear, mon_image[6], relay_output_b}, 3'b000)
    emg = 0;
    step(1);
    `CHK({mon_image[6], relay_output_b, input_fault_mask}, {mdl_flt, mdl_flt, 1'b0})
    input_fault = 0;
    step(2);
    test_done;
  end
endmodule
